// File: hdl/vt_supervision_pkg.sv
/*
  Constants, codes and carrier types of the voltage transformer supervision stage.
  Assumes a 100 MHz system clock and a 5 ms program cycle.
*/
package vt_supervision_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYCLE_NS = 5000000;
  localparam int PROG_CYCLE_MS = 5;
  localparam int STAMP_NS = 1000000;
  localparam int ANGLE_LOOKBACK_MS = 40;
  localparam int PREFAULT_MS = 20;
  localparam int HIST_DEPTH = ANGLE_LOOKBACK_MS / PROG_CYCLE_MS;
  localparam int PRE_N = PREFAULT_MS / PROG_CYCLE_MS;
  // Window ends PREFAULT_MS back, first entry is four cycles old
  localparam int PRE_FIRST = PREFAULT_MS / PROG_CYCLE_MS - 1;
  localparam int PRE_SHIFT = $clog2(PRE_N);
  localparam int TICK_W = 20;
  localparam int MSC_W = 17;

  localparam int VOLT_W = 16;
  localparam int ANG_W = 12;
  localparam int TH_W = 7;
  localparam int ALIM_W = 10;
  localparam int DLY_W = 19;
  localparam int REM_W = 20;
  localparam int CNT_W = 16;
  localparam int TS_W = 32;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 5;
  localparam int NUM_OUT = 4;

  // Angles in 0.1 degree, voltages and thresholds in 0.01 x nominal
  localparam logic [ANG_W-1:0] ANG_FULL = 12'hE10;
  localparam logic [ANG_W-1:0] ANG_HALF = 12'h708;
  localparam logic [TH_W-1:0] LOW_TH_RST = 7'h05;
  localparam logic [TH_W-1:0] HIGH_TH_RST = 7'h50;
  localparam logic [ALIM_W-1:0] ALIM_RST = 10'h032;
  localparam logic [DLY_W-1:0] DELAY_RST = 19'h00014;

  localparam int CTRL_BUS_CHK = 0;
  localparam int CTRL_LINE_CHK = 1;
  localparam int CTRL_FORCE_EN = 2;
  localparam int CTRL_SW_BLOCK = 3;
  localparam int CTRL_SEL_LL = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h03;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LOW_TH = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_TH = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_ALIM = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_DELAY = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_EXPECT = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_REMAIN = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CNT_CLR = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 4'h9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_ALARM = 2'b11,
    ST_BLOCKED = 2'b10
  } state_t;

  typedef logic [2:0] code_t;
  localparam code_t BUS_DEAD = 3'h0;
  localparam code_t BUS_OK = 3'h1;
  localparam code_t BUS_REV = 3'h2;
  localparam code_t BUS_UNDEF = 3'h3;
  localparam code_t BUS_FAULT = 3'h4;
  localparam code_t COND_NORMAL = 3'h0;
  localparam code_t COND_START = 3'h1;
  localparam code_t COND_LINE = 3'h2;
  localparam code_t COND_BUS = 3'h3;
  localparam code_t COND_BLOCKED = 3'h4;

  typedef enum logic [1:0] {
    FT_NONE = 2'h0,
    FT_BUS_VT = 2'h1,
    FT_BUS_FUSE = 2'h2,
    FT_LINE_FUSE = 2'h3
  } fault_t;

  // Output index: start, bus alarm, line alarm, blocked
  localparam int OUT_START = 0;
  localparam int OUT_BUS = 1;
  localparam int OUT_LINE = 2;
  localparam int OUT_BLK = 3;

  typedef logic [2:0][VOLT_W-1:0] volt3_t;
  typedef struct packed {
    volt3_t ph_volt;
    volt3_t ll_volt;
    logic [VOLT_W-1:0] positive_seq_voltage;
    logic [VOLT_W-1:0] negative_seq_voltage;
    logic [VOLT_W-1:0] zero_seq_voltage;
    logic [2:0][ANG_W-1:0] ph_ang;
    logic [2:0][ANG_W-1:0] ll_ang;
  } meas_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] id;
    logic on;
    logic [TS_W-1:0] stamp;
    fault_t fault;
    volt3_t volt;
  } event_t;
endpackage

// File: hdl/vt_supervision.sv
/*
  Voltage transformer supervision stage, run once per 5 ms program cycle.
  Assumes measurements and binary inputs synchronous to clk_sys and held
  stable by the front end across each program cycle tick.
*/
// Behaviour
// - evaluate voltages, sequences, angles every 5 ms
// - report 20 ms average ending 20 ms back
// - pick-up on one low or two high
// - low threshold, 0.01 steps, default 0.05
// - high threshold, default 0.80 of nominal
// - angle steady on all three phases versus 40 ms ago blocks voltage pick-up, not fuse pick-up
// - bus fuse check enables bus trip input
// - line fuse check enables line trip input
// - start only while blocking inactive
// - fuse input pick-up without filtering
// - bus voltage status codes zero to four
// - condition status codes zero to four
// - expected operating time readable, 5 ms units
// - signed remaining time while counting down
// - blocking sampled at program cycle start
// - unblocked pick-up starts and times
// - blocked pick-up gives blocked, nothing else
// - blocking resets active start
// - blocking raises display and stamped event
// - test mode switch drives blocking
// - definite time delay before alarm
// - four outputs with events and counters
// - event stamps in 1 ms resolution
`timescale 1ns/1ps
module vt_supervision #(
  parameter int TICK_CYCLES =
    vt_supervision_pkg::PROG_CYCLE_NS / vt_supervision_pkg::CLK_PERIOD_NS,
  parameter int MS_CYCLES =
    vt_supervision_pkg::STAMP_NS / vt_supervision_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire vt_supervision_pkg::reg_req_t reg_req,
  output vt_supervision_pkg::reg_req_t rd_echo_unused,
  output logic [vt_supervision_pkg::DATA_W-1:0] rd_data,
  // Measurements and binary inputs
  input wire vt_supervision_pkg::meas_t meas,
  input wire logic block_in,
  input wire logic bus_breaker_trip_input,
  input wire logic line_breaker_trip_input,
  // Function outputs
  output logic start_out,
  output logic alarm_bus_out,
  output logic alarm_line_out,
  output logic blocked_out,
  output vt_supervision_pkg::code_t bus_status,
  output vt_supervision_pkg::code_t cond_status,
  output vt_supervision_pkg::volt3_t prefault_volt,
  // Events
  output logic evt_valid,
  output vt_supervision_pkg::event_t evt,
  output logic display_event
);
  import vt_supervision_pkg::*;

  logic [TICK_W-1:0] tick_cnt_reg;
  logic [MSC_W-1:0] ms_cnt_reg;
  logic [TS_W-1:0] stamp_reg;
  logic tick;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [TH_W-1:0] low_th_reg;
  logic [TH_W-1:0] high_th_reg;
  logic [ALIM_W-1:0] alim_reg;
  logic [DLY_W-1:0] delay_reg;
  logic cnt_clr;
  volt3_t volt_sel;
  logic [2:0][ANG_W-1:0] ang_sel;
  logic [2:0] low_hit;
  logic [2:0] high_hit;
  logic [2:0] ang_still;
  volt3_t pre_avg;
  logic volt_pick, ang_block, vt_pick, bus_fuse, line_fuse, pick, blk_now;
  fault_t fault_now;
  state_t state_reg, state_next;
  logic [REM_W-1:0] remain_reg, remain_next;
  logic [NUM_OUT-1:0] out_now, out_old_reg;
  logic [2*NUM_OUT-1:0] pend_reg, pend_set, pend_sel;
  logic [2:0] pend_idx;
  logic [NUM_OUT-1:0][CNT_W-1:0] cnt_reg;
  fault_t fault_reg;
  volt3_t snap_reg;

  assign rd_echo_unused = '0;
  assign tick = (tick_cnt_reg == '0);
  assign out_now = {blocked_out, alarm_line_out, alarm_bus_out, start_out};

  // Program cycle and 1 ms stamp time bases
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= TICK_W'(TICK_CYCLES - 1);
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_reg <= '0;
      stamp_reg <= '0;
    end else if (ms_cnt_reg == MSC_W'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= '0;
      stamp_reg <= stamp_reg + 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  // Settings written by software
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RST;
      low_th_reg <= LOW_TH_RST;
      high_th_reg <= HIGH_TH_RST;
      alim_reg <= ALIM_RST;
      delay_reg <= DELAY_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_CTRL: ctrl_reg <= reg_req.wdata[CTRL_W-1:0];
        ADDR_LOW_TH: low_th_reg <= reg_req.wdata[TH_W-1:0];
        ADDR_HIGH_TH: high_th_reg <= reg_req.wdata[TH_W-1:0];
        ADDR_ALIM: alim_reg <= reg_req.wdata[ALIM_W-1:0];
        ADDR_DELAY: delay_reg <= reg_req.wdata[DLY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  assign cnt_clr = reg_req.wr && (reg_req.addr == ADDR_CNT_CLR);
  assign volt_sel = ctrl_reg[CTRL_SEL_LL] ? meas.ll_volt : meas.ph_volt;
  assign ang_sel = ctrl_reg[CTRL_SEL_LL] ? meas.ll_ang : meas.ph_ang;

  // Per phase comparators, angle and voltage history
  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic [HIST_DEPTH-1:0][ANG_W-1:0] ang_hist_reg;
    logic [HIST_DEPTH-1:0][VOLT_W-1:0] volt_hist_reg;
    logic [ANG_W-1:0] diff;
    logic [ANG_W-1:0] wrap;
    logic [VOLT_W+PRE_SHIFT-1:0] sum;

    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        ang_hist_reg <= '0;
        volt_hist_reg <= '0;
      end else if (tick) begin
        ang_hist_reg <= {ang_hist_reg[HIST_DEPTH-2:0], ang_sel[p]};
        volt_hist_reg <= {volt_hist_reg[HIST_DEPTH-2:0], volt_sel[p]};
      end
    end

    always_comb begin
      sum = '0;
      for (int k = 0; k < PRE_N; k++) begin
        sum = sum + (VOLT_W+PRE_SHIFT)'(volt_hist_reg[PRE_FIRST+k]);
      end
    end
    assign pre_avg[p] = VOLT_W'(sum >> PRE_SHIFT);

    assign diff = (ang_sel[p] >= ang_hist_reg[HIST_DEPTH-1]) ?
      ang_sel[p] - ang_hist_reg[HIST_DEPTH-1] :
      ang_hist_reg[HIST_DEPTH-1] - ang_sel[p];
    // Shortest way round the circle
    assign wrap = (diff > ANG_HALF) ? ANG_FULL - diff : diff;
    assign ang_still[p] = wrap < ANG_W'(alim_reg);
    assign low_hit[p] = volt_sel[p] < VOLT_W'(low_th_reg);
    assign high_hit[p] = volt_sel[p] > VOLT_W'(high_th_reg);
  end

  // Pick-up sources
  assign volt_pick = (|low_hit) || (high_hit[0] && high_hit[1]) ||
    (high_hit[1] && high_hit[2]) || (high_hit[0] && high_hit[2]);
  assign ang_block = &ang_still;
  assign vt_pick = volt_pick && !ang_block;
  assign bus_fuse = ctrl_reg[CTRL_BUS_CHK] && bus_breaker_trip_input;
  assign line_fuse = ctrl_reg[CTRL_LINE_CHK] && line_breaker_trip_input;
  assign pick = vt_pick || bus_fuse || line_fuse;
  // Test switch overrides the matrix only under stage forcing
  assign blk_now = ctrl_reg[CTRL_FORCE_EN] ? ctrl_reg[CTRL_SW_BLOCK] : block_in;

  always_comb begin
    if (bus_fuse) begin
      fault_now = FT_BUS_FUSE;
    end else if (vt_pick) begin
      fault_now = FT_BUS_VT;
    end else if (line_fuse) begin
      fault_now = FT_LINE_FUSE;
    end else begin
      fault_now = FT_NONE;
    end
  end

  // Stage sequence, stepped only on the program cycle tick
  always_comb begin
    state_next = state_reg;
    remain_next = remain_reg;
    if (tick) begin
      case (state_reg)
        ST_IDLE, ST_BLOCKED: begin
          remain_next = REM_W'(delay_reg);
          if (!pick) begin
            state_next = ST_IDLE;
          end else if (blk_now) begin
            state_next = ST_BLOCKED;
          end else begin
            state_next = ST_START;
          end
        end
        ST_START: begin
          if (!pick || blk_now) begin
            state_next = pick ? ST_BLOCKED : ST_IDLE;
            remain_next = REM_W'(delay_reg);
          end else if (remain_reg <= REM_W'(1)) begin
            state_next = ST_ALARM;
            remain_next = '0;
          end else begin
            remain_next = remain_reg - 1'b1;
          end
        end
        ST_ALARM: begin
          if (!pick || blk_now) begin
            state_next = pick ? ST_BLOCKED : ST_IDLE;
            remain_next = REM_W'(delay_reg);
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      remain_reg <= REM_W'(DELAY_RST);
    end else begin
      state_reg <= state_next;
      remain_reg <= remain_next;
    end
  end

  // Outputs and status codes refresh once per program cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_out <= 1'b0;
      alarm_bus_out <= 1'b0;
      alarm_line_out <= 1'b0;
      blocked_out <= 1'b0;
      bus_status <= BUS_DEAD;
      cond_status <= COND_NORMAL;
      fault_reg <= FT_NONE;
      snap_reg <= '0;
    end else if (tick) begin
      start_out <= (state_next == ST_START) || (state_next == ST_ALARM);
      alarm_bus_out <= (state_next == ST_ALARM) && (fault_now != FT_LINE_FUSE);
      alarm_line_out <= (state_next == ST_ALARM) && (fault_now == FT_LINE_FUSE);
      blocked_out <= state_next == ST_BLOCKED;
      fault_reg <= fault_now;
      snap_reg <= volt_sel;
      if (&low_hit) begin
        bus_status <= BUS_DEAD;
      end else if (pick) begin
        bus_status <= BUS_FAULT;
      end else if (meas.positive_seq_voltage > meas.negative_seq_voltage) begin
        bus_status <= BUS_OK;
      end else if (meas.positive_seq_voltage < meas.negative_seq_voltage) begin
        bus_status <= BUS_REV;
      end else begin
        bus_status <= BUS_UNDEF;
      end
      case (state_next)
        ST_BLOCKED: cond_status <= COND_BLOCKED;
        ST_START: cond_status <= COND_START;
        ST_ALARM: cond_status <= (fault_now == FT_LINE_FUSE) ? COND_LINE : COND_BUS;
        default: cond_status <= COND_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefault_volt <= '0;
    end else if (tick && (state_reg != ST_START) && (state_reg != ST_ALARM) &&
                 (state_next == ST_START)) begin
      prefault_volt <= pre_avg;
    end
  end

  // Events: several may change together, so they queue one per cycle
  always_comb begin
    pend_set = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (out_now[i] != out_old_reg[i]) begin
        pend_set[2*i+(out_now[i] ? 1 : 0)] = 1'b1;
      end
    end
    pend_sel = pend_reg & (~pend_reg + 1'b1);
    pend_idx = '0;
    for (int j = 0; j < 2*NUM_OUT; j++) begin
      if (pend_sel[j]) begin
        pend_idx = 3'(j);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_old_reg <= '0;
      pend_reg <= '0;
      evt_valid <= 1'b0;
      evt <= '0;
      display_event <= 1'b0;
    end else begin
      out_old_reg <= out_now;
      pend_reg <= (pend_reg & ~pend_sel) | pend_set;
      evt_valid <= |pend_reg;
      evt.id <= pend_idx[2:1];
      evt.on <= pend_idx[0];
      evt.stamp <= stamp_reg;
      evt.fault <= fault_reg;
      evt.volt <= snap_reg;
      display_event <= blocked_out && !out_old_reg[OUT_BLK];
    end
  end

  // Cumulative counters; a rising output beats a clear in the same cycle
  for (genvar c = 0; c < NUM_OUT; c++) begin : g_cnt
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        cnt_reg[c] <= '0;
      end else if (out_now[c] && !out_old_reg[c]) begin
        cnt_reg[c] <= cnt_clr ? CNT_W'(1) : cnt_reg[c] + 1'b1;
      end else if (cnt_clr) begin
        cnt_reg[c] <= '0;
      end
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL: rd_data <= DATA_W'(ctrl_reg);
        ADDR_LOW_TH: rd_data <= DATA_W'(low_th_reg);
        ADDR_HIGH_TH: rd_data <= DATA_W'(high_th_reg);
        ADDR_ALIM: rd_data <= DATA_W'(alim_reg);
        ADDR_DELAY: rd_data <= DATA_W'(delay_reg);
        ADDR_STATUS: rd_data <= DATA_W'({state_reg, cond_status, bus_status});
        ADDR_EXPECT: rd_data <= DATA_W'(delay_reg);
        ADDR_REMAIN: rd_data <= DATA_W'(signed'(remain_reg));
        ADDR_CNT_BASE: rd_data <= DATA_W'(cnt_reg[OUT_START]);
        ADDR_CNT_BASE + 4'h1: rd_data <= DATA_W'(cnt_reg[OUT_BUS]);
        ADDR_CNT_BASE + 4'h2: rd_data <= DATA_W'(cnt_reg[OUT_LINE]);
        ADDR_CNT_BASE + 4'h3: rd_data <= DATA_W'(cnt_reg[OUT_BLK]);
        default: rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  property p_tick_spacing;
    @(posedge clk_sys) disable iff (!reset_n) tick |=> !tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too close");

  property p_start_unblocked;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(start_out) |-> $past(tick) && !$past(blk_now);
  endproperty
  a_start_unblocked: assert property (p_start_unblocked) else $error("start under block");

  property p_block_on_pick;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && pick && blk_now && (state_reg == ST_IDLE) |=>
        blocked_out && !start_out && (cond_status == COND_BLOCKED);
  endproperty
  a_block_on_pick: assert property (p_block_on_pick) else $error("blocked not set");

  property p_block_resets_start;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && start_out && blk_now |=> !start_out && !alarm_bus_out;
  endproperty
  a_block_resets_start: assert property (p_block_resets_start) else $error("start kept");

  property p_low_pick;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && (|low_hit) && !ang_block && !blk_now && (state_reg == ST_IDLE) |=>
        start_out && (remain_reg == REM_W'(delay_reg));
  endproperty
  a_low_pick: assert property (p_low_pick) else $error("low pick-up missed");

  property p_fuse_now;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && ctrl_reg[CTRL_BUS_CHK] && bus_breaker_trip_input && !blk_now && !(&low_hit)
        && (state_reg == ST_IDLE) |=> start_out && (bus_status == BUS_FAULT);
  endproperty
  a_fuse_now: assert property (p_fuse_now) else $error("fuse pick-up late");

  property p_line_check_off;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && !ctrl_reg[CTRL_LINE_CHK] && !vt_pick && !bus_fuse
        && (state_reg == ST_IDLE) |=> !start_out;
  endproperty
  a_line_check_off: assert property (p_line_check_off) else $error("line trip unchecked");

  property p_alarm_after_delay;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(alarm_bus_out || alarm_line_out) |->
        $past(state_reg) == ST_START && $past(remain_reg) <= REM_W'(1);
  endproperty
  a_alarm_after_delay: assert property (p_alarm_after_delay) else $error("early alarm");

  property p_drop_clears;
    @(posedge clk_sys) disable iff (!reset_n)
      tick && (state_reg == ST_START) && !pick |=>
        !start_out && !alarm_bus_out && !alarm_line_out && (state_reg == ST_IDLE);
  endproperty
  a_drop_clears: assert property (p_drop_clears) else $error("drop not cleared");

  property p_count_start;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(start_out) && !cnt_clr |=> cnt_reg[OUT_START] == $past(cnt_reg[OUT_START]) + 1'b1;
  endproperty
  a_count_start: assert property (p_count_start) else $error("start not counted");

  property p_display_block;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(blocked_out) |=> display_event ##[1:8] (evt_valid && evt.id == 2'h3 && evt.on);
  endproperty
  a_display_block: assert property (p_display_block) else $error("block event missing");
endmodule // vt_supervision

// File: testbench/meas_source.sv
/*
  Measurement front end model: voltages as levels, angles turning each clock.
  Assumes the bench changes the levels just after a rising clock edge.
*/
`timescale 1ns/1ps
module meas_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Levels from the bench
  input wire vt_supervision_pkg::volt3_t volt,
  input wire logic spin,
  // To the stage
  output vt_supervision_pkg::meas_t meas
);
  import vt_supervision_pkg::*;
  logic [ANG_W-1:0] ang_reg;
  // Moving angles keep the shift check from holding voltage pick-up off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ang_reg <= '0;
    end else if (spin) begin
      ang_reg <= (ang_reg >= ANG_FULL - 12'h003) ? '0 : ang_reg + 12'h003;
    end
  end
  always_comb begin
    meas = '0;
    meas.ph_volt = volt;
    meas.ll_volt = volt;
    meas.positive_seq_voltage = volt[0];
    // Half of the third level, so the bench can order or tie the sequence
    meas.negative_seq_voltage = volt[2] >> 1;
    meas.ph_ang = {3{ang_reg}};
    meas.ll_ang = {3{ang_reg}};
  end
endmodule // meas_source

// File: testbench/testbench.sv
/*
  Self-checking bench of the supervision stage: registers, pick-up, blocking, alarms.
  Assumes a program cycle shortened to 20 clocks through TICK_CYCLES.
*/
`timescale 1ns/1ps
module testbench;
  import vt_supervision_pkg::*;
  localparam int TICK = 20;
  logic clk_sys, reset_n, block_in, bus_trip, line_trip, spin, evt_valid;
  logic start_out, alarm_bus_out, alarm_line_out, blocked_out, display_event;
  logic [DATA_W-1:0] rd_data;
  reg_req_t req;
  meas_t meas;
  volt3_t volt, pre_v;
  event_t evt, last_evt;
  int disp_cnt = 0;
  code_t bus_status, cond_status;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  vt_supervision #(.TICK_CYCLES(TICK), .MS_CYCLES(4)) i_dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_req(req), .rd_echo_unused(), .rd_data(rd_data), .meas(meas),
    .block_in(block_in), .bus_breaker_trip_input(bus_trip), .line_breaker_trip_input(line_trip),
    .start_out(start_out), .alarm_bus_out(alarm_bus_out), .alarm_line_out(alarm_line_out),
    .blocked_out(blocked_out), .bus_status(bus_status), .cond_status(cond_status),
    .prefault_volt(pre_v), .evt_valid(evt_valid), .evt(evt), .display_event(display_event));
  meas_source i_src (.clk_sys(clk_sys), .reset_n(reset_n), .volt(volt), .spin(spin),
    .meas(meas));
  task automatic ck(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, got);
    end
  endtask
  task automatic bk(input string n, input logic got, input logic exp);
    ck(n, 32'(got), 32'(exp));
  endtask
  task automatic sk(input string n, input code_t got, input code_t exp);
    ck(n, 32'(got), 32'(exp));
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rk(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 ck(n, rd_data, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk_sys);
    // Step past the edge so outputs launched on it are settled
    #1;
  endtask
  task automatic setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk_sys);
    volt <= {c, b, a};
  endtask
  task automatic t_defaults;
    rk("ctrl", ADDR_CTRL, 32'h3);
    rk("low", ADDR_LOW_TH, 32'h5);
    rk("high", ADDR_HIGH_TH, 32'h50);
    rk("alim", ADDR_ALIM, 32'h32);
    rk("expect", ADDR_EXPECT, 32'h14);
    rk("unmapped", 4'hF, 32'h0);
  endtask
  task automatic t_alarm;
    wr(ADDR_DELAY, 32'h3);
    rk("expect", ADDR_EXPECT, 32'h3);
    setv(16'h0000, 16'h0000, 16'h0000);
    ticks(3);
    sk("dead", bus_status, BUS_DEAD);
    setv(16'h0032, 16'h0032, 16'h0032);
    ticks(10);
    sk("ok", bus_status, BUS_OK);
    bk("idle", start_out, 1'b0);
    wr(ADDR_CNT_CLR, 32'h0);
    setv(16'h0002, 16'h0032, 16'h0032);
    ticks(2);
    bk("start", start_out, 1'b1);
    sk("cond", cond_status, COND_START);
    sk("fault", bus_status, BUS_FAULT);
    ck("prefault", 32'(pre_v[0]), 32'h32);
    ticks(4);
    bk("bus alarm", alarm_bus_out, 1'b1);
    bk("line alarm", alarm_line_out, 1'b0);
    rk("cnt start", ADDR_CNT_BASE, 32'h1);
    rk("cnt bus", ADDR_CNT_BASE + 4'h1, 32'h1);
    setv(16'h0032, 16'h0032, 16'h0032);
    ticks(3);
  endtask
  task automatic t_drop;
    wr(ADDR_DELAY, 32'hA);
    setv(16'h005A, 16'h005A, 16'h0032);
    ticks(3);
    bk("two high", start_out, 1'b1);
    rk("remain", ADDR_REMAIN, 32'h8);
    setv(16'h0032, 16'h0032, 16'h0032);
    ticks(2);
    bk("dropped", start_out, 1'b0);
    ticks(10);
    bk("no alarm", alarm_bus_out, 1'b0);
    setv(16'h0010, 16'h0032, 16'h0050);
    ticks(1);
    sk("rev", bus_status, BUS_REV);
    setv(16'h0014, 16'h0032, 16'h0028);
    ticks(1);
    sk("undef", bus_status, BUS_UNDEF);
  endtask
  task automatic t_angle;
    @(posedge clk_sys);
    spin <= 1'b0;
    ticks(10);
    setv(16'h0002, 16'h0032, 16'h0032);
    ticks(3);
    bk("steady angle", start_out, 1'b0);
    @(posedge clk_sys);
    spin <= 1'b1;
    ticks(3);
    bk("moving angle", start_out, 1'b1);
  endtask
  task automatic t_block;
    int d0;
    @(posedge clk_sys);
    block_in <= 1'b1;
    ticks(3);
    bk("blocked", blocked_out, 1'b1);
    bk("no start", start_out, 1'b0);
    sk("cond", cond_status, COND_BLOCKED);
    @(posedge clk_sys);
    block_in <= 1'b0;
    ticks(2);
    bk("unblocked", start_out, 1'b1);
    @(posedge clk_sys);
    d0 = disp_cnt;
    block_in <= 1'b1;
    ticks(2);
    bk("start reset", start_out, 1'b0);
    ck("display", 32'(disp_cnt - d0), 32'h1);
    ck("blk evt", 32'({last_evt.id, last_evt.on, last_evt.fault}), 32'({2'h3, 1'b1, FT_BUS_VT}));
    ck("evt volt", 32'(last_evt.volt[0]), 32'h2);
    @(posedge clk_sys);
    block_in <= 1'b0;
    setv(16'h0032, 16'h0032, 16'h0032);
    ticks(3);
  endtask
  task automatic t_fuse;
    wr(ADDR_DELAY, 32'h3);
    line_trip <= 1'b1;
    ticks(1);
    bk("line fuse", start_out, 1'b1);
    ticks(4);
    bk("line alarm", alarm_line_out, 1'b1);
    bk("bus alarm", alarm_bus_out, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    ticks(3);
    bk("line unchecked", start_out, 1'b0);
    bus_trip <= 1'b1;
    ticks(1);
    bk("bus fuse", start_out, 1'b1);
    ticks(4);
    bk("bus alarm", alarm_bus_out, 1'b1);
    wr(ADDR_CTRL, 32'hD);
    ticks(3);
    bk("forced", blocked_out, 1'b1);
    line_trip <= 1'b0;
    bus_trip <= 1'b0;
    wr(ADDR_CTRL, 32'h3);
    ticks(3);
    bk("released", blocked_out, 1'b0);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (display_event === 1'b1) begin
      disp_cnt++;
    end
    if (evt_valid === 1'b1) begin
      last_evt <= evt;
    end
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    reset_n = 1'b0;
    req = '0;
    block_in = 1'b0;
    bus_trip = 1'b0;
    line_trip = 1'b0;
    spin = 1'b1;
    last_evt = '0;
    volt = {3{16'h0032}};
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_defaults();
    t_alarm();
    t_drop();
    t_angle();
    t_block();
    t_fuse();
    results();
  end
endmodule // testbench
